// >>> rtl/fdbp_pkg.sv
// constants, register map and mode type for the flexible dual-bus data port
package fdbp_pkg;

    // ------------------------------------------------------------------
    // bus widths and drive patterns
    // ------------------------------------------------------------------
    localparam int unsigned BUS_W       = 10;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [BUS_W-1:0] BUS_ZERO     = 10'h000;
    localparam logic [BUS_W-1:0] BUS_ALL_ON   = 10'h3FF;
    localparam logic [BUS_W-1:0] BUS_MSB_ONLY = 10'h200;
    localparam int unsigned BUS_MSB     = 9;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W      = 8;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_COUNT   = 8'h08;

    // control: register configuration enable, mode, system clock on pin two
    localparam int unsigned CTRL_REGCFG_BIT = 0;
    localparam int unsigned CTRL_MODE_LSB   = 1;
    localparam int unsigned CTRL_SYSCLK_BIT = 3;
    localparam logic [31:0] CTRL_MASK       = 32'h0000000F;
    localparam logic [31:0] CTRL_RESET      = 32'h00000000;

    // status fields
    localparam int unsigned ST_MODE_LSB  = 0;
    localparam int unsigned ST_DIRTX_BIT = 2;
    localparam int unsigned ST_REGCFG_BIT = 3;
    localparam int unsigned ST_PINFD_BIT = 4;
    localparam int unsigned ST_PINW_BIT  = 5;
    localparam int unsigned ST_CAPT_BIT  = 6;

    // count register: receive samples low half, transmit samples high half
    localparam int unsigned CNT_W       = 16;
    localparam int unsigned CNT_TX_LSB  = 16;

    localparam logic [31:0] WORD_ZERO   = 32'h00000000;

    // ------------------------------------------------------------------
    // interface modes, encoded as held in the control register
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        full_duplex_mode,
        half_duplex_interleaved,
        half_duplex_parallel,
        compat_mode
    } fdbp_mode_t;

endpackage

// >>> rtl/fdbp_port.sv
// flexible dual-bus data port: pin-side converter data interface with apb control
`timescale 1ns/1ps
`default_nettype none

module fdbp_port #(
    parameter int unsigned WORD_CYC = 8
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         clk_en,
    input  wire logic [fdbp_pkg::ADDR_W-1:0]  paddr,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         mode_pin_full_duplex,
    input  wire logic [fdbp_pkg::BUS_W-1:0]   upper_data_bus_in,
    output logic      [fdbp_pkg::BUS_W-1:0]   upper_data_bus_out,
    output logic      [fdbp_pkg::BUS_W-1:0]   upper_data_bus_oe,
    input  wire logic [fdbp_pkg::BUS_W-1:0]   lower_data_bus_in,
    output logic      [fdbp_pkg::BUS_W-1:0]   lower_data_bus_out,
    output logic      [fdbp_pkg::BUS_W-1:0]   lower_data_bus_oe,
    input  wire logic                         interface_pin_first_in,
    input  wire logic                         interface_pin_second_in,
    output logic                              interface_pin_second_out,
    output logic                              interface_pin_second_oe,
    output logic                              interface_pin_third_out,
    input  wire logic [fdbp_pkg::BUS_W-1:0]   rx_a_in,
    input  wire logic [fdbp_pkg::BUS_W-1:0]   rx_b_in,
    input  wire logic                         rx_strobe,
    output logic      [fdbp_pkg::BUS_W-1:0]   tx_a_out,
    output logic      [fdbp_pkg::BUS_W-1:0]   tx_b_out,
    output logic                              tx_valid
);

    localparam int unsigned BW     = fdbp_pkg::BUS_W;
    localparam int unsigned SYNC_W = 2 * BW + 3;
    localparam int unsigned HALF   = WORD_CYC / 2;
    localparam int unsigned CNT_WW = $clog2(WORD_CYC);
    localparam logic [CNT_WW-1:0] SLOT_LAST = CNT_WW'(WORD_CYC - 1);
    localparam logic [CNT_WW-1:0] SLOT_RISE = CNT_WW'(HALF - 1);
    // pins are read two cycles after the rising edge, through the synchroniser
    localparam logic [CNT_WW-1:0] SLOT_LATCH = CNT_WW'(HALF + 1);
    localparam logic [1:0] CAPT_AT = 2'(fdbp_pkg::SYNC_STAGES);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (WORD_CYC < 4 || (WORD_CYC % 2) != 0) begin : g_bad_word_cyc
        $error("WORD_CYC must be even and at least 4");
    end

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic [BW-1:0]     s_upper;
    logic [BW-1:0]     s_lower;
    logic              s_first;
    logic              s_second;
    logic              s_strap;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (clk_en) begin
            sync1_r <= {mode_pin_full_duplex, interface_pin_second_in,
                        interface_pin_first_in, lower_data_bus_in,
                        upper_data_bus_in};
            sync2_r <= sync1_r;
        end
    end

    assign s_upper  = sync2_r[BW-1:0];
    assign s_lower  = sync2_r[2*BW-1:BW];
    assign s_first  = sync2_r[2*BW];
    assign s_second = sync2_r[2*BW+1];
    assign s_strap  = sync2_r[2*BW+2];

    // ------------------------------------------------------------------
    // mode pin capture
    // ------------------------------------------------------------------
    // the synchroniser must fill before the straps are trusted
    logic [1:0] capt_cnt_r;
    logic       captured_r;
    logic       pin_fd_r;
    logic       pin_width_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capt_cnt_r  <= 2'h0;
            captured_r  <= 1'b0;
            pin_fd_r    <= 1'b0;
            pin_width_r <= 1'b0;
        end else if (clk_en && !captured_r) begin
            if (capt_cnt_r == CAPT_AT) begin
                captured_r  <= 1'b1;
                pin_fd_r    <= s_strap;
                pin_width_r <= s_second;
            end else begin
                capt_cnt_r <= capt_cnt_r + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // apb register slave, one wait state per access
    // ------------------------------------------------------------------
    logic [31:0]            ctrl_r;
    logic [31:0]            prdata_r;
    logic                   pready_r;
    logic                   pslverr_r;
    logic [31:0]            status_w;
    fdbp_pkg::fdbp_mode_t   mode_r;
    logic                   dir_tx_r;
    logic [fdbp_pkg::CNT_W-1:0] rx_cnt_r;
    logic [fdbp_pkg::CNT_W-1:0] tx_cnt_r;

    always_comb begin
        status_w = fdbp_pkg::WORD_ZERO;
        status_w[fdbp_pkg::ST_MODE_LSB +: 2] = mode_r;
        status_w[fdbp_pkg::ST_DIRTX_BIT]     = dir_tx_r;
        status_w[fdbp_pkg::ST_REGCFG_BIT]    =
            ctrl_r[fdbp_pkg::CTRL_REGCFG_BIT];
        status_w[fdbp_pkg::ST_PINFD_BIT]     = pin_fd_r;
        status_w[fdbp_pkg::ST_PINW_BIT]      = pin_width_r;
        status_w[fdbp_pkg::ST_CAPT_BIT]      = captured_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r    <= fdbp_pkg::CTRL_RESET;
            prdata_r  <= fdbp_pkg::WORD_ZERO;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (clk_en) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            if (psel && penable && !pready_r) begin
                pready_r <= 1'b1;
                prdata_r <= fdbp_pkg::WORD_ZERO;
                case (paddr)
                    fdbp_pkg::OFS_CTRL: begin
                        if (pwrite) begin
                            ctrl_r <= pwdata & fdbp_pkg::CTRL_MASK;
                        end else begin
                            prdata_r <= ctrl_r;
                        end
                    end
                    fdbp_pkg::OFS_STATUS: begin
                        if (!pwrite) begin
                            prdata_r <= status_w;
                        end
                    end
                    fdbp_pkg::OFS_COUNT: begin
                        if (!pwrite) begin
                            prdata_r <= {tx_cnt_r, rx_cnt_r};
                        end
                    end
                    default: begin
                        pslverr_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------------
    // effective mode and direction
    // ------------------------------------------------------------------
    logic                 reg_cfg;
    fdbp_pkg::fdbp_mode_t mode_nxt;

    assign reg_cfg = ctrl_r[fdbp_pkg::CTRL_REGCFG_BIT];

    always_comb begin
        if (reg_cfg) begin
            mode_nxt = fdbp_pkg::fdbp_mode_t'(
                ctrl_r[fdbp_pkg::CTRL_MODE_LSB +: 2]);
        end else if (pin_fd_r) begin
            mode_nxt = fdbp_pkg::full_duplex_mode;
        end else if (pin_width_r) begin
            mode_nxt = fdbp_pkg::half_duplex_interleaved;
        end else begin
            mode_nxt = fdbp_pkg::half_duplex_parallel;
        end
    end

    // ------------------------------------------------------------------
    // word slot timing and forwarded clocks
    // ------------------------------------------------------------------
    // mode and direction change only at a slot boundary so a word is
    // never cut short on the bus
    logic [CNT_WW-1:0] slot_cnt_r;
    logic              slot_end;
    logic              clk_r;
    logic              sysclk_r;
    logic              clk_nxt;
    logic              mode_ok_r;

    assign slot_end = (slot_cnt_r == SLOT_LAST);

    always_comb begin
        clk_nxt = clk_r;
        if (slot_end) begin
            clk_nxt = 1'b0;
        end else if (slot_cnt_r == SLOT_RISE) begin
            clk_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_cnt_r <= '0;
            clk_r      <= 1'b0;
            sysclk_r   <= 1'b0;
            mode_r     <= fdbp_pkg::full_duplex_mode;
            dir_tx_r   <= 1'b0;
            mode_ok_r  <= 1'b0;
        end else if (clk_en) begin
            slot_cnt_r <= slot_end ? '0 : slot_cnt_r + 1'b1;
            clk_r      <= clk_nxt;
            sysclk_r   <= ~sysclk_r;
            if (slot_end) begin
                mode_r   <= mode_nxt;
                dir_tx_r <= s_first;
                // the data buses and pin two stay undriven until the straps have set the mode
                mode_ok_r <= captured_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // clock pins
    // ------------------------------------------------------------------
    // the system clock is forwarded halved: a flop cannot pass pclk itself
    logic if2_out_r;
    logic if2_oe_r;
    logic if3_out_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            if2_out_r <= 1'b0;
            if2_oe_r  <= 1'b0;
            if3_out_r <= 1'b0;
        end else if (clk_en) begin
            if3_out_r <= clk_nxt;
            if (reg_cfg) begin
                if2_out_r <= ~sysclk_r;
                if2_oe_r  <= mode_ok_r &&
                             ((mode_r == fdbp_pkg::full_duplex_mode) ||
                             ctrl_r[fdbp_pkg::CTRL_SYSCLK_BIT]);
            end else begin
                if2_out_r <= clk_nxt;
                if2_oe_r  <= mode_ok_r &&
                             (mode_r == fdbp_pkg::full_duplex_mode);
            end
        end
    end

    assign interface_pin_second_out = if2_out_r;
    assign interface_pin_second_oe  = if2_oe_r;
    assign interface_pin_third_out  = if3_out_r;

    // ------------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------------
    logic          rx_active;
    logic          interleaved;
    logic [BW-1:0] rx_pend_a_r;
    logic [BW-1:0] rx_pend_b_r;
    logic [BW-1:0] rx_hold_a_r;
    logic [BW-1:0] rx_hold_b_r;
    logic          phase_b_r;
    logic [BW-1:0] up_out_r;
    logic [BW-1:0] up_oe_r;
    logic [BW-1:0] lo_out_r;
    logic [BW-1:0] lo_oe_r;

    assign rx_active = mode_ok_r &&
                       ((mode_r == fdbp_pkg::full_duplex_mode) ||
                       !dir_tx_r);
    assign interleaved = (mode_r == fdbp_pkg::full_duplex_mode) ||
                         (mode_r == fdbp_pkg::half_duplex_interleaved);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pend_a_r <= fdbp_pkg::BUS_ZERO;
            rx_pend_b_r <= fdbp_pkg::BUS_ZERO;
        end else if (clk_en && rx_strobe) begin
            rx_pend_a_r <= rx_a_in;
            rx_pend_b_r <= rx_b_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hold_a_r <= fdbp_pkg::BUS_ZERO;
            rx_hold_b_r <= fdbp_pkg::BUS_ZERO;
            phase_b_r   <= 1'b0;
            rx_cnt_r    <= '0;
            up_out_r    <= fdbp_pkg::BUS_ZERO;
            up_oe_r     <= fdbp_pkg::BUS_ZERO;
            lo_out_r    <= fdbp_pkg::BUS_ZERO;
            lo_oe_r     <= fdbp_pkg::BUS_ZERO;
        end else if (clk_en && slot_end) begin
            up_out_r <= fdbp_pkg::BUS_ZERO;
            up_oe_r  <= fdbp_pkg::BUS_ZERO;
            lo_out_r <= fdbp_pkg::BUS_ZERO;
            lo_oe_r  <= fdbp_pkg::BUS_ZERO;
            if (!rx_active) begin
                phase_b_r <= 1'b0;
            end else if (interleaved) begin
                // both words of one pair come from the same sample
                phase_b_r <= ~phase_b_r;
                if (!phase_b_r) begin
                    rx_hold_a_r <= rx_pend_a_r;
                    rx_hold_b_r <= rx_pend_b_r;
                    rx_cnt_r    <= rx_cnt_r + 1'b1;
                end
                lo_out_r <= phase_b_r ? rx_hold_b_r : rx_pend_a_r;
                lo_oe_r  <= fdbp_pkg::BUS_ALL_ON;
                if (mode_r == fdbp_pkg::half_duplex_interleaved) begin
                    up_out_r[fdbp_pkg::BUS_MSB] <= phase_b_r;
                    up_oe_r  <= fdbp_pkg::BUS_MSB_ONLY;
                end
            end else begin
                phase_b_r   <= 1'b0;
                rx_hold_a_r <= rx_pend_a_r;
                rx_hold_b_r <= rx_pend_b_r;
                rx_cnt_r    <= rx_cnt_r + 1'b1;
                up_out_r    <= rx_pend_b_r;
                lo_out_r    <= rx_pend_a_r;
                up_oe_r     <= fdbp_pkg::BUS_ALL_ON;
                lo_oe_r     <= fdbp_pkg::BUS_ALL_ON;
            end
        end
    end

    assign upper_data_bus_out = up_out_r;
    assign upper_data_bus_oe  = up_oe_r;
    assign lower_data_bus_out = lo_out_r;
    assign lower_data_bus_oe  = lo_oe_r;

    // ------------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------------
    // a B word without a preceding A word is dropped: no pair can be made
    logic          tx_active;
    logic          tx_marker;
    logic [BW-1:0] tx_first_r;
    logic          a_seen_r;
    logic [BW-1:0] tx_a_r;
    logic [BW-1:0] tx_b_r;
    logic          tx_valid_r;

    assign tx_active = mode_ok_r &&
                       ((mode_r == fdbp_pkg::full_duplex_mode) ||
                       dir_tx_r);
    assign tx_marker = (mode_r == fdbp_pkg::full_duplex_mode) ?
                       s_first : s_lower[fdbp_pkg::BUS_MSB];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_first_r <= fdbp_pkg::BUS_ZERO;
            a_seen_r   <= 1'b0;
            tx_a_r     <= fdbp_pkg::BUS_ZERO;
            tx_b_r     <= fdbp_pkg::BUS_ZERO;
            tx_valid_r <= 1'b0;
            tx_cnt_r   <= '0;
        end else if (clk_en) begin
            tx_valid_r <= 1'b0;
            if (!tx_active) begin
                a_seen_r <= 1'b0;
            end else if (slot_cnt_r == SLOT_LATCH) begin
                if (mode_r == fdbp_pkg::half_duplex_parallel) begin
                    tx_a_r     <= s_upper;
                    tx_b_r     <= s_lower;
                    tx_valid_r <= 1'b1;
                    tx_cnt_r   <= tx_cnt_r + 1'b1;
                end else if (tx_marker) begin
                    tx_first_r <= s_upper;
                    a_seen_r   <= 1'b1;
                end else if (a_seen_r) begin
                    tx_a_r     <= tx_first_r;
                    tx_b_r     <= s_upper;
                    tx_valid_r <= 1'b1;
                    a_seen_r   <= 1'b0;
                    tx_cnt_r   <= tx_cnt_r + 1'b1;
                end
            end
        end
    end

    assign tx_a_out = tx_a_r;
    assign tx_b_out = tx_b_r;
    assign tx_valid = tx_valid_r;

endmodule

`default_nettype wire

// >>> tb/fdbp_port_monitor.sv
// assertion checker bound to the dual-bus data port
`timescale 1ns/1ps
`default_nettype none
module fdbp_port_monitor #(
    parameter int unsigned WORD_CYC = 8
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [9:0]  upper_data_bus_out,
    input wire logic [9:0]  upper_data_bus_oe,
    input wire logic [9:0]  lower_data_bus_out,
    input wire logic [9:0]  lower_data_bus_oe,
    input wire logic        interface_pin_third_out,
    input wire logic        tx_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // --------
    // checks timed for an eight clock slot
    // --------
    AST_APB_WAIT:
        assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    AST_READY_PULSE:
        assert property (pready |=> !pready)
        else $error("pready too long");
    AST_UNMAPPED:
        assert property (psel && penable && !pready && !(paddr inside
            {8'h00, 8'h04, 8'h08}) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_TXV_PULSE:
        assert property (tx_valid |=> !tx_valid)
        else $error("tx_valid too long");
    AST_CLK_HALF:
        assert property ($rose(interface_pin_third_out)
            |-> interface_pin_third_out[*4] ##1 !interface_pin_third_out)
        else $error("word clock high time wrong");
    AST_RX_STANDS:
        assert property ($changed(lower_data_bus_out) && &lower_data_bus_oe
            |-> !interface_pin_third_out ##1 $stable(lower_data_bus_out)[*7])
        else $error("rx word not held for a slot");
    AST_OE_SHAPE:
        assert property ((upper_data_bus_oe inside {10'h000, 10'h200, 10'h3FF})
            && (lower_data_bus_oe inside {10'h000, 10'h3FF})
            && (upper_data_bus_oe == 10'h000 || &lower_data_bus_oe))
        else $error("bus drive pattern wrong");
    AST_MARKER_TOGGLE:
        assert property ($rose(interface_pin_third_out)
            && upper_data_bus_oe == 10'h200 |-> ##8 (upper_data_bus_oe !=
            10'h200 || upper_data_bus_out[9] != $past(upper_data_bus_out[9], 8)))
        else $error("rx marker did not alternate");
endmodule
bind fdbp_port fdbp_port_monitor #(.WORD_CYC(WORD_CYC)) i_fdbp_port_monitor (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .upper_data_bus_out(upper_data_bus_out),
    .upper_data_bus_oe(upper_data_bus_oe),
    .lower_data_bus_out(lower_data_bus_out),
    .lower_data_bus_oe(lower_data_bus_oe),
    .interface_pin_third_out(interface_pin_third_out), .tx_valid(tx_valid));
`default_nettype wire

// >>> tb/fdbp_host_model.sv
// back end model: sends transmit words, latches receive words
`timescale 1ns/1ps
`default_nettype none
module fdbp_host_model (
    input  wire logic        pclk,
    input  wire logic        clk3,
    input  wire logic        txen,
    input  wire logic        par,
    input  wire logic [9:0]  wa,
    input  wire logic [9:0]  wb,
    input  wire logic [9:0]  uo,
    input  wire logic [9:0]  uoe,
    input  wire logic [9:0]  lo,
    input  wire logic [9:0]  loe,
    output logic      [9:0]  ui,
    output logic      [9:0]  li,
    output var logic         mk,
    output var logic  [9:0]  cu,
    output var logic  [19:0] cl
);
    logic       c3q = 1'h0;
    logic [9:0] lu  = 10'h000;
    logic [9:0] ll  = 10'h000;
    initial mk = 1'h0;
    // --------
    // words move after the clock falls, latched as it rises
    // --------
    always @(posedge pclk) begin
        c3q <= clk3;
        lu <= ui;
        ll <= li;
        if (c3q && !clk3) mk <= par | ~mk;
        if (!c3q && clk3) begin
            cu <= uo;
            cl <= {cl[9:0], lo};
        end
    end
    // released lines toggle so a stale level never looks valid
    assign ui = uoe & uo | ~uoe & (txen ? (mk ? wa : wb) : ~lu);
    assign li = loe & lo | ~loe
        & (txen ? (par ? wb : {mk, ~ll[8:0]}) : ~ll);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking testbench for the dual-bus data port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, fdp = 1'h1, w20 = 1'h0, dir = 1'h0;
    logic        fdm = 1'h1, txen = 1'h0, par = 1'h0, stb = 1'h0;
    logic        pready, pslverr, o2, oe2, c3, txv, mk;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h45;
    logic [9:0]  ra = 10'h000, rb = 10'h000, wa = 10'h000, wb = 10'h000;
    logic [9:0]  ui, li, uo, uoe, lo, loe, cu, ta, tbv;
    logic [19:0] cl;
    int          n_mismatch = 0, checked = 0, ntx = 0, cyc = 0;
    fdbp_port #(.WORD_CYC(8)) i_fdbp_port (.pclk(pclk), .presetn(presetn),
        .clk_en(1'h1), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_pin_full_duplex(fdp),
        .upper_data_bus_in(ui), .upper_data_bus_out(uo),
        .upper_data_bus_oe(uoe), .lower_data_bus_in(li),
        .lower_data_bus_out(lo), .lower_data_bus_oe(loe),
        .interface_pin_first_in(fdm ? mk : dir),
        .interface_pin_second_in(oe2 ? o2 : w20),
        .interface_pin_second_out(o2), .interface_pin_second_oe(oe2),
        .interface_pin_third_out(c3), .rx_a_in(ra), .rx_b_in(rb),
        .rx_strobe(stb), .tx_a_out(ta), .tx_b_out(tbv), .tx_valid(txv));
    fdbp_host_model i_fdbp_host_model (.pclk(pclk), .clk3(c3), .txen(txen),
        .par(par), .wa(wa), .wb(wb), .uo(uo), .uoe(uoe), .lo(lo),
        .loe(loe), .ui(ui), .li(li), .mk(mk), .cu(cu), .cl(cl));
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        stb <= cyc % 8 == 0;
        if (txv) ntx <= ntx + 1;
    end
    // --------
    // shared tasks
    // --------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'h1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) begin n_mismatch++; summarize(); end
        @(posedge pclk);
    endtask
    task automatic run(input logic [31:0] ctl, input logic [1:0] m,
        input logic d);
        logic [31:0] r;
        logic e;
        logic s;
        int n0;
        apb(1'h1, 8'h00, ctl, r, e);
        apb(1'h0, 8'h00, 32'h0, r, e);
        chk(r, ctl);
        r = rnd();
        ra <= r[9:0];
        rb <= ~r[9:0];
        wa <= r[19:10];
        wb <= r[29:20];
        dir <= d;
        fdm <= m == 2'h0;
        txen <= m == 2'h0 || d;
        par <= m == 2'h2;
        repeat (24) @(posedge pclk);
        n0 = ntx;
        repeat (40) @(posedge pclk);
        if (!d || m == 2'h0) begin
            if (m[1]) chk({cu, cl[9:0]}, {rb, ra});
            else chk(cl == {ra, rb} || cl == {rb, ra}, 32'h1);
            if (m == 2'h1) chk(cu[9], cl[9:0] == rb);
        end
        if (d || m == 2'h0) begin
            chk({ntx > n0, tbv, ta}, {1'h1, wb, wa});
        end else begin
            chk(ntx - n0, 0);
        end
        // the system clock on pin two must toggle every cycle
        s = o2;
        @(posedge pclk);
        if (ctl == 32'h1) chk({oe2, o2 ^ s}, 32'h3);
        if (ctl == 32'h0 && m == 2'h0) chk({oe2, o2}, {1'h1, c3});
    endtask
    // --------
    // main sequence
    // --------
    initial begin
        logic [31:0] r;
        logic e;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        repeat (5) @(posedge pclk);
        fdp <= 1'h0;
        w20 <= 1'h1;
        apb(1'h0, 8'h04, 32'h0, r, e);
        chk(r & 32'h73, 32'h50);
        run(32'h0, 2'h0, 1'h0);
        for (int i = 0; i < 8; i++) run({29'h0, i[1:0], 1'h1}, i[1:0], i[2]);
        apb(1'h0, 8'h0C, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        // the mode field follows the straps only after the first slot
        repeat (12) @(posedge pclk);
        apb(1'h0, 8'h04, 32'h0, r, e);
        chk(r & 32'h73, 32'h61);
        run(32'h0, 2'h1, 1'h0);
        summarize();
    end
endmodule
`default_nettype wire
